// File: shared/pin_change_pkg.sv
package pin_change_pkg;

	// register byte offsets on the AXI4-Lite slave
	localparam logic [5:0] OFF_PORTA_RISE  = 6'h00;
	localparam logic [5:0] OFF_PORTA_FALL  = 6'h04;
	localparam logic [5:0] OFF_PORTA_FLAGS = 6'h08;
	localparam logic [5:0] OFF_PORTB_RISE  = 6'h0C;
	localparam logic [5:0] OFF_PORTB_FALL  = 6'h10;
	localparam logic [5:0] OFF_PORTB_FLAGS = 6'h14;
	localparam logic [5:0] OFF_PORTC_RISE  = 6'h18;
	localparam logic [5:0] OFF_PORTC_FALL  = 6'h1C;
	localparam logic [5:0] OFF_PORTC_FLAGS = 6'h20;
	localparam logic [5:0] OFF_IRQ_CTRL    = 6'h24;

	// implemented bits per port
	localparam logic [7:0] MASK_PORTA      = 8'h3F;
	localparam logic [7:0] MASK_PORTB      = 8'hF0;
	localparam logic [7:0] MASK_PORTC      = 8'hFF;
	localparam logic [7:0] MASK_PORTC_SMALL = 8'h3F;

	// control register fields
	localparam int         POS_IRQ_ENABLE  = 0;
	localparam int         POS_IRQ_FLAG    = 1;

	localparam logic [7:0] RESET_BYTE      = 8'h00;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;
	localparam int         NUM_PORTS       = 3;

	typedef struct packed {
		logic [7:0] rise;
		logic [7:0] fall;
		logic [7:0] flags;
	} port_regs_t;

	typedef struct packed {
		logic [7:0] meta;
		logic [7:0] sync;
		logic [7:0] prev;
	} pin_sync_t;

endpackage : pin_change_pkg

// File: core/pin_change_detect.sv
// Function
// - each pin has its own independent rising and falling edge detectors
// - rising detection armed only while the pin's rise_enable bit is one
// - falling detection armed only while the pin's fall_enable bit is one
// - both enable bits set detects edges of either direction together
// - enabled edge sets the pin's change flag until software clears it
// - interrupt raised only while change_irq_enable is set; flags still set
// - change_irq_flag is the OR of every change flag of all ports
// - software writing zero to a change flag bit clears it
// - an edge during a flag write leaves that flag set regardless
// - with change_irq_enable set, a detected edge wakes the core from sleep
// - edges in sleep are recorded before the first instruction after wake
// - port A implements bits 5 to 0; bits 7 and 6 read zero
// - port B on the large variant implements bits 7 to 4 only
// - port C rise enables bits 7 to 0; bits 7 and 6 large variant only
// - enable bits are read write and reset to zero on every reset
// - flag bits read write, hardware settable, reset to zero
// - port C fall enables bits 7 to 0 arm falling detection; bits 7 and 6 large variant only
// - port C flags set on enabled rise or fall, cleared by software
`timescale 1ns/1ns
`default_nettype none

module pin_change_detect #(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [7:0]  portAPin,
	input  wire logic [7:0]  portBPin,
	input  wire logic [7:0]  portCPin,
	input  wire logic        sleepActive,
	output logic             changeIrq,
	output logic             wakeRequest,
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	typedef struct packed {
		pin_change_pkg::port_regs_t [2:0] ports;
		pin_change_pkg::pin_sync_t  [2:0] pins;
		logic                             irqEnable;
		logic                             irq;
		logic                             wake;
		logic                             awHeld;
		logic [5:0]                       awAddr;
		logic                             wHeld;
		logic [7:0]                       wData;
		logic                             wLane0;
		logic                             bValid;
		logic [1:0]                       bResp;
		logic                             rValid;
		logic [31:0]                      rData;
		logic [1:0]                       rResp;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	logic [2:0][7:0] pinIn;
	logic [2:0][7:0] implMask;
	logic [2:0][7:0] edgeHit;
	logic            anyFlag;

	assign pinIn[0] = portAPin;
	assign pinIn[1] = portBPin;
	assign pinIn[2] = portCPin;
	assign implMask[0] = pin_change_pkg::MASK_PORTA;
	assign implMask[1] = LARGE_PACKAGE ? pin_change_pkg::MASK_PORTB
		: pin_change_pkg::RESET_BYTE;
	assign implMask[2] = LARGE_PACKAGE ? pin_change_pkg::MASK_PORTC
		: pin_change_pkg::MASK_PORTC_SMALL;

	// register index from a byte offset: port number and field, or none
	function automatic logic [3:0] decode(input logic [5:0] addr);
		unique case (addr)
			pin_change_pkg::OFF_PORTA_RISE:  decode = 4'h0;
			pin_change_pkg::OFF_PORTA_FALL:  decode = 4'h1;
			pin_change_pkg::OFF_PORTA_FLAGS: decode = 4'h2;
			pin_change_pkg::OFF_PORTB_RISE:  decode = 4'h4;
			pin_change_pkg::OFF_PORTB_FALL:  decode = 4'h5;
			pin_change_pkg::OFF_PORTB_FLAGS: decode = 4'h6;
			pin_change_pkg::OFF_PORTC_RISE:  decode = 4'h8;
			pin_change_pkg::OFF_PORTC_FALL:  decode = 4'h9;
			pin_change_pkg::OFF_PORTC_FLAGS: decode = 4'hA;
			pin_change_pkg::OFF_IRQ_CTRL:    decode = 4'hC;
			default:                         decode = 4'hF;
		endcase
	endfunction : decode

	////////////////////////////////////////////////////////////////////////
	// edge detection
	always_comb begin
		for (int p = 0; p < pin_change_pkg::NUM_PORTS; p++) begin
			// rising and falling per pin, each gated by its own enable
			edgeHit[p] = ((state_r.pins[p].sync & ~state_r.pins[p].prev
				& state_r.ports[p].rise)
				| (~state_r.pins[p].sync & state_r.pins[p].prev
				& state_r.ports[p].fall))
				& implMask[p];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [3:0] wIdx;
		logic [3:0] rIdx;
		logic [7:0] rByte;
		logic [1:0] port;
		wIdx = 4'h0;
		rIdx = 4'h0;
		rByte = pin_change_pkg::RESET_BYTE;
		port = 2'h0;
		state_nxt = state_r;

		// two flops then previous sample; nothing reads meta but sync
		for (int p = 0; p < pin_change_pkg::NUM_PORTS; p++) begin
			state_nxt.pins[p].meta = pinIn[p];
			state_nxt.pins[p].sync = state_r.pins[p].meta;
			state_nxt.pins[p].prev = state_r.pins[p].sync;
		end

		// write address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			state_nxt.awHeld = 1'b1;
			state_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_nxt.wHeld = 1'b1;
			state_nxt.wData = s_axi_wdata[7:0];
			state_nxt.wLane0 = s_axi_wstrb[0];
		end

		if (state_r.awHeld && state_r.wHeld && !state_r.bValid) begin
			wIdx = decode(state_r.awAddr);
			state_nxt.awHeld = 1'b0;
			state_nxt.wHeld = 1'b0;
			state_nxt.bValid = 1'b1;
			state_nxt.bResp = (wIdx == 4'hF) ? pin_change_pkg::RESP_SLVERR
				: pin_change_pkg::RESP_OKAY;
			port = wIdx[3:2];
			if (state_r.wLane0 && wIdx != 4'hF) begin
				if (wIdx == 4'hC) begin
					state_nxt.irqEnable =
						state_r.wData[pin_change_pkg::POS_IRQ_ENABLE];
				end else if (wIdx[1:0] == 2'h0) begin
					state_nxt.ports[port].rise =
						state_r.wData & implMask[port];
				end else if (wIdx[1:0] == 2'h1) begin
					state_nxt.ports[port].fall =
						state_r.wData & implMask[port];
				end else begin
					// ones leave a flag alone, zeros clear it
					state_nxt.ports[port].flags =
						state_r.ports[port].flags & state_r.wData;
				end
			end
		end
		if (state_r.bValid && s_axi_bready) begin
			state_nxt.bValid = 1'b0;
		end

		// hardware set applied last so it beats a same cycle clear
		for (int p = 0; p < pin_change_pkg::NUM_PORTS; p++) begin
			state_nxt.ports[p].flags = (state_nxt.ports[p].flags
				| edgeHit[p]) & implMask[p];
		end

		// read channel
		if (s_axi_arvalid && s_axi_arready) begin
			rIdx = decode(s_axi_araddr);
			port = rIdx[3:2];
			if (rIdx == 4'hC) begin
				rByte[pin_change_pkg::POS_IRQ_ENABLE] = state_r.irqEnable;
				rByte[pin_change_pkg::POS_IRQ_FLAG] = anyFlag;
			end else if (rIdx != 4'hF) begin
				unique case (rIdx[1:0])
					2'h0:    rByte = state_r.ports[port].rise;
					2'h1:    rByte = state_r.ports[port].fall;
					default: rByte = state_r.ports[port].flags;
				endcase
			end
			state_nxt.rValid = 1'b1;
			state_nxt.rData = {24'h000000, rByte};
			state_nxt.rResp = (rIdx == 4'hF) ? pin_change_pkg::RESP_SLVERR
				: pin_change_pkg::RESP_OKAY;
		end else if (state_r.rValid && s_axi_rready) begin
			state_nxt.rValid = 1'b0;
		end

		// interrupt output gated by the master enable; flags and summary flag set regardless
		state_nxt.irq = state_r.irqEnable && anyFlag;
		// flags are already registered when wake rises, ahead of any fetch
		state_nxt.wake = state_r.irqEnable && sleepActive && anyFlag;
	end

	assign anyFlag = |{state_r.ports[0].flags, state_r.ports[1].flags,
		state_r.ports[2].flags};

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// one write and one read at a time keeps the slave free of queues
	assign s_axi_awready = !state_r.awHeld && !state_r.bValid;
	assign s_axi_wready  = !state_r.wHeld && !state_r.bValid;
	assign s_axi_arready = !state_r.rValid;
	assign s_axi_bvalid  = state_r.bValid;
	assign s_axi_bresp   = state_r.bResp;
	assign s_axi_rvalid  = state_r.rValid;
	assign s_axi_rdata   = state_r.rData;
	assign s_axi_rresp   = state_r.rResp;
	assign changeIrq     = state_r.irq;
	assign wakeRequest   = state_r.wake;

endmodule : pin_change_detect

`default_nettype wire

// File: sim/pin_change_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pin_change_sva (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        sleepActive,
	input wire logic        changeIrq,
	input wire logic        wakeRequest,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_wake_sleep: assert property (
		wakeRequest |-> changeIrq && $past(sleepActive)) else $error("bad wake");
	a_wake_follow: assert property (
		changeIrq && $past(sleepActive) |-> wakeRequest) else $error("no wake");
	a_wake_drop: assert property (
		wakeRequest && !sleepActive |=> !wakeRequest) else $error("wake stuck");
	// a flag only leaves by a write, so the irq may only drop near a response
	a_irq_fall: assert property (
		$fell(changeIrq) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("irq dropped without write");
	a_b_refuse: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw open");
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b lost");
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("r lost");
	a_r_refuse: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
	a_r_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper set");
endmodule : pin_change_sva
`default_nettype wire

// File: sim/pin_source.sv
`timescale 1ns/1ns
`default_nettype none
module pin_source (
	input  wire logic [23:0] target,
	input  wire logic        slow,
	output logic      [7:0]  portAPin,
	output logic      [7:0]  portBPin,
	output logic      [7:0]  portCPin
);
	// pins move 30 ns after target changes at a rising edge, 530 ns when slow, clear of both clock edges
	initial forever begin
		{portCPin, portBPin, portAPin} <= #(slow ? 530 : 30) target;
		@(target);
	end
endmodule : pin_source
`default_nettype wire

// File: sim/tb_pin_change_detect.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pin_change_detect;
	localparam logic [1:0] OK  = pin_change_pkg::RESP_OKAY;
	localparam logic [5:0] FA  = pin_change_pkg::OFF_PORTA_FLAGS;
	localparam logic [5:0] CTL = pin_change_pkg::OFF_IRQ_CTRL;
	logic        clk_sys, rst_b, sleepActive, slow;
	logic [7:0]  portAPin, portBPin, portCPin;
	logic [23:0] target = 24'h0;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, got;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, changeIrq, wakeRequest;
	int          fail_count = 0;
	int          checks_done = 0;
	pin_change_detect dut (.*);
	pin_source far (.target(target), .slow(slow), .portAPin(portAPin),
		.portBPin(portBPin), .portCPin(portCPin));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : check
	// readies are sampled mid-cycle, since inputs only move at rising edges
	task automatic wr(input logic [5:0] a, input logic [7:0] d,
		input logic [1:0] er);
		logic aT, wT, bT;
		int   n = 0;
		@(posedge clk_sys);
		{s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge clk_sys);
			aT = s_axi_awvalid & s_axi_awready;
			wT = s_axi_wvalid & s_axi_wready;
			bT = s_axi_bvalid;
			resp = bT ? s_axi_bresp : 2'h3;
			n++;
			@(posedge clk_sys);
			if (aT) s_axi_awvalid <= 1'h0;
			if (wT) s_axi_wvalid <= 1'h0;
		end while (!bT && n < 40);
		s_axi_bready <= 1'h0;
		check({30'h0, resp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic arT, rT;
		int   n = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(negedge clk_sys);
			arT = s_axi_arvalid & s_axi_arready;
			rT = s_axi_rvalid;
			got = s_axi_rdata;
			resp = rT ? s_axi_rresp : 2'h3;
			n++;
			@(posedge clk_sys);
			if (arT) s_axi_arvalid <= 1'h0;
		end while (!rT && n < 40);
		s_axi_rready <= 1'h0;
		check(got, e);
		check({30'h0, resp}, {30'h0, er});
	endtask : rd
	task automatic pins_to(input logic [23:0] v);
		target <= v;
		repeat (12) @(posedge clk_sys);
	endtask : pins_to
	task automatic reset_values();
		for (int i = 0; i < 10; i++)
			rd(6'(i * 4), 32'h0, OK);
	endtask : reset_values
	task automatic unmapped();
		rd(6'h28, 32'h0, pin_change_pkg::RESP_SLVERR);
		wr(6'h3C, 8'hFF, pin_change_pkg::RESP_SLVERR);
	endtask : unmapped
	task automatic enable_masks();
		for (int i = 0; i < 6; i++) begin
			wr(6'((i + i / 2) * 4), 8'hFF, OK);
			rd(6'((i + i / 2) * 4), {24'h0, i < 2 ? 8'h3F : i < 4 ? 8'hF0 : 8'hFF},
				OK);
		end
	endtask : enable_masks
	task automatic edge_flags();
		wr(6'h00, 8'h09, OK);
		wr(6'h04, 8'h0A, OK);
		pins_to(24'hFFFF0F);
		rd(FA, 32'h09, OK);
		rd(6'h14, 32'hF0, OK);
		rd(6'h20, 32'hFF, OK);
		rd(CTL, 32'h02, OK);
		check({31'h0, changeIrq}, 32'h0);
		wr(FA, 8'hF6, OK);
		rd(CTL, 32'h02, OK);
		wr(6'h14, 8'h00, OK);
		wr(6'h20, 8'h00, OK);
		rd(CTL, 32'h00, OK);
		pins_to(24'hFFFF00);
		rd(FA, 32'h0A, OK);
		wr(FA, 8'h00, OK);
	endtask : edge_flags
	task automatic sleep_wake();
		wr(CTL, 8'h01, OK);
		sleepActive <= 1'h1;
		slow <= 1'h1;
		pins_to(24'hFFFF09);
		@(negedge clk_sys);
		check({31'h0, wakeRequest}, 32'h1);
		check({31'h0, changeIrq}, 32'h1);
		@(posedge clk_sys);
		{sleepActive, slow} <= 2'h0;
		rd(FA, 32'h09, OK);
		rd(CTL, 32'h03, OK);
		wr(FA, 8'h00, OK);
		@(negedge clk_sys);
		check({31'h0, changeIrq}, 32'h0);
		wr(CTL, 8'h00, OK);
	endtask : sleep_wake
	// the pin edge is lined up to land on the same edge as the write
	task automatic clear_race();
		@(posedge clk_sys);
		target <= 24'hFFFF00;
		wr(FA, 8'h00, OK);
		rd(FA, 32'h08, OK);
	endtask : clear_race
	task automatic tally_and_finish();
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#400000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		{rst_b, sleepActive, slow, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'h1;
		reset_values();
		unmapped();
		enable_masks();
		edge_flags();
		sleep_wake();
		clear_race();
		tally_and_finish();
	end
endmodule : tb_pin_change_detect
bind pin_change_detect pin_change_sva chk (.*);
`default_nettype wire
